// ### verilog/mtc_pkg.sv
// What this block does
// R1: Pass and fail outputs are low-true and show the limit result of the next reading to go out.
// R2: Each reading sent drives the matching output low for about 2 ms.
// R3: With USB disabled the pass and fail levels are routed onto the connector data contacts.
// R4: Disabling USB enables the pass/fail function; enabling USB returns the contacts to USB.
// R5: A read query moves the trigger machine from idle to wait-for-trigger.
// R6: After read or initiate, a measurement starts only when the trigger condition holds.
// R7: In read mode each result goes straight to the output buffer, not to memory.
// R8: The host drains the output buffer; a full buffer stalls further measurements.
// R9: Initiate enters wait-for-trigger and triggered results are stored in memory.
// R10: A fetch query copies stored readings into the output buffer.
// R11: Configure sets function, range and resolution, stays idle, takes no reading.
// R12: Measure applies settings, takes one reading and sends it to the output buffer.
// R13: Triggers are accepted only in wait-for-trigger and ignored otherwise.
// R14: Trigger source is immediate, software bus trigger or external input.
// R15: When the requested readings are done the machine returns to idle.
package mtc_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int PULSE_US = 2000;
    localparam int PULSE_CYC = PULSE_US * (CLK_HZ / 1000000);
    localparam int RDG_W = 24;
    localparam int CNT_W = 16;
    localparam int CFG_W = 16;

    typedef enum logic [3:0] {
        MTC_CMD_NONE = 4'h0,
        MTC_CMD_CONF = 4'h1,
        MTC_CMD_MEAS = 4'h2,
        MTC_CMD_READ = 4'h3,
        MTC_CMD_INIT = 4'h4,
        MTC_CMD_FETCH = 4'h5
    } mtc_cmd_t;

    typedef enum logic [1:0] {
        MTC_SRC_IMM = 2'h0,
        MTC_SRC_BUS = 2'h1,
        MTC_SRC_EXT = 2'h2
    } mtc_src_t;

    typedef enum logic [4:0] {
        MTC_ST_IDLE = 5'b00001,
        MTC_ST_WAIT = 5'b00010,
        MTC_ST_MEAS = 5'b00100,
        MTC_ST_PUSH = 5'b01000,
        MTC_ST_FETCH = 5'b10000
    } mtc_state_t;

    typedef struct packed {
        logic valid;
        logic [RDG_W-1:0] value;
        logic pass;
    } mtc_rdg_t;
endpackage : mtc_pkg

// ### verilog/mtc_ctrl.sv
`timescale 1ns/1ns
module mtc_ctrl #(
    parameter int DEPTH = 512,
    parameter int PULSE_CYCLES = mtc_pkg::PULSE_CYC
) (
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    input wire logic CMD_VALID_I,
    input wire mtc_pkg::mtc_cmd_t CMD_I,
    input wire logic [mtc_pkg::CFG_W-1:0] CMD_CFG_I,
    input wire logic [mtc_pkg::CNT_W-1:0] CMD_COUNT_I,
    input wire mtc_pkg::mtc_src_t TRIG_SRC_I,
    input wire logic BUS_TRIG_I,
    input wire logic EXT_TRIG_I,
    output logic MEAS_START_O,
    output logic [mtc_pkg::CFG_W-1:0] MEAS_CFG_O,
    input wire mtc_pkg::mtc_rdg_t MEAS_RESULT_I,
    output mtc_pkg::mtc_rdg_t OUT_DATA_O,
    input wire logic OUT_READY_I,
    output logic BUSY_O,
    output logic WAIT_TRIG_O,
    input wire logic USB_ENABLE_I,
    output logic USB_DM_O,
    output logic USB_DP_O,
    output logic USB_DM_OE_O,
    output logic USB_DP_OE_O,
    output logic PF_ACTIVE_O
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        mtc_pkg::mtc_state_t st;
        logic to_mem;
        logic fetch_all;
        logic [mtc_pkg::CNT_W-1:0] left;
        logic [mtc_pkg::CFG_W-1:0] cfg;
        logic start;
        mtc_pkg::mtc_rdg_t held;
        mtc_pkg::mtc_rdg_t out;
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
        logic [31:0] pulse;
        logic pass_n;
        logic fail_n;
    } mtc_state_reg_t;

    mtc_state_reg_t s_reg;
    mtc_state_reg_t s_next;
    mtc_pkg::mtc_rdg_t mem [DEPTH];
    logic trig_ok;
    logic mem_we;
    logic out_free;
    logic word_load;

    ////////////////////////////////////////////////////////////////////////
    // Trigger source select
    always_comb begin
        case (TRIG_SRC_I) // R14
            mtc_pkg::MTC_SRC_IMM: trig_ok = 1'b1;
            mtc_pkg::MTC_SRC_BUS: trig_ok = BUS_TRIG_I;
            mtc_pkg::MTC_SRC_EXT: trig_ok = EXT_TRIG_I;
            default: trig_ok = 1'b0;
        endcase
    end

    // Output word slot frees when the host takes it
    assign out_free = !s_reg.out.valid || OUT_READY_I;

    always_comb begin
        s_next = s_reg;
        s_next.start = 1'b0;
        mem_we = 1'b0;
        word_load = 1'b0;
        if (s_reg.out.valid && OUT_READY_I) begin
            s_next.out.valid = 1'b0;
        end
        case (s_reg.st)
            mtc_pkg::MTC_ST_IDLE: begin
                if (CMD_VALID_I) begin
                    case (CMD_I)
                        mtc_pkg::MTC_CMD_CONF: begin
                            s_next.cfg = CMD_CFG_I; // R11
                        end
                        mtc_pkg::MTC_CMD_MEAS: begin
                            s_next.cfg = CMD_CFG_I; // R12
                            s_next.to_mem = 1'b0;
                            s_next.left = {{(mtc_pkg::CNT_W-1){1'b0}}, 1'b1};
                            s_next.st = mtc_pkg::MTC_ST_WAIT;
                        end
                        mtc_pkg::MTC_CMD_READ: begin
                            s_next.to_mem = 1'b0; // R7
                            s_next.left = CMD_COUNT_I;
                            s_next.st = mtc_pkg::MTC_ST_WAIT; // R5
                        end
                        mtc_pkg::MTC_CMD_INIT: begin
                            // Initiate discards what an earlier run stored
                            s_next.to_mem = 1'b1;
                            s_next.wr_ptr = '0;
                            s_next.rd_ptr = '0;
                            s_next.left = CMD_COUNT_I;
                            s_next.st = mtc_pkg::MTC_ST_WAIT; // R9
                        end
                        mtc_pkg::MTC_CMD_FETCH: begin
                            // Fetch always replays from the first reading
                            s_next.rd_ptr = '0;
                            s_next.st = mtc_pkg::MTC_ST_FETCH; // R10
                        end
                        default: begin
                        end
                    endcase
                end
            end
            mtc_pkg::MTC_ST_WAIT: begin
                // A zero count returns to idle without a reading
                if (s_reg.left == '0) begin
                    s_next.st = mtc_pkg::MTC_ST_IDLE; // R15
                end else if (!s_reg.to_mem && !out_free) begin
                    // In read mode no reading starts while its word has nowhere to go
                    s_next.st = mtc_pkg::MTC_ST_WAIT; // R8
                end else if (trig_ok) begin // R6 R13
                    s_next.start = 1'b1;
                    s_next.st = mtc_pkg::MTC_ST_MEAS;
                end
            end
            mtc_pkg::MTC_ST_MEAS: begin
                if (MEAS_RESULT_I.valid) begin
                    s_next.held = MEAS_RESULT_I;
                    s_next.st = mtc_pkg::MTC_ST_PUSH;
                end
            end
            mtc_pkg::MTC_ST_PUSH: begin
                if (s_reg.to_mem) begin
                    // Memory full drops the rest rather than wrapping
                    if (s_reg.wr_ptr < (AW+1)'(DEPTH)) begin
                        mem_we = 1'b1; // R9
                        s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
                    end
                    s_next.left = s_reg.left - 1'b1;
                    s_next.st = mtc_pkg::MTC_ST_WAIT;
                end else if (out_free) begin // R8
                    s_next.out = s_reg.held; // R7
                    s_next.out.valid = 1'b1;
                    s_next.left = s_reg.left - 1'b1;
                    s_next.st = mtc_pkg::MTC_ST_WAIT;
                end
            end
            mtc_pkg::MTC_ST_FETCH: begin
                if (s_reg.rd_ptr == s_reg.wr_ptr) begin
                    s_next.st = mtc_pkg::MTC_ST_IDLE;
                end else if (out_free) begin // R10 R8
                    s_next.out = mem[s_reg.rd_ptr[AW-1:0]];
                    s_next.out.valid = 1'b1;
                    s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
                end
            end
            default: s_next.st = mtc_pkg::MTC_ST_IDLE;
        endcase
        // Limit pulse follows the word that goes out next on the bus
        // A new word restarts the pulse so the lines never show a stale result
        word_load = s_next.out.valid && (!s_reg.out.valid || OUT_READY_I);
        if (word_load) begin
            s_next.pulse = 32'(PULSE_CYCLES); // R2
            s_next.pass_n = !s_next.out.pass; // R1
            s_next.fail_n = s_next.out.pass;
        end else if (s_reg.pulse != '0) begin
            s_next.pulse = s_reg.pulse - 1'b1;
            if (s_reg.pulse == 32'h0000_0001) begin
                s_next.pass_n = 1'b1;
                s_next.fail_n = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; the limit lines idle high
    always_ff @(posedge CLOCK_I) begin
        if (SYS_RST_I) begin
            s_reg <= '0;
            s_reg.st <= mtc_pkg::MTC_ST_IDLE;
            s_reg.pass_n <= 1'b1;
            s_reg.fail_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Array kept out of reset so it can map to block RAM
    always_ff @(posedge CLOCK_I) begin
        if (mem_we) begin
            mem[s_reg.wr_ptr[AW-1:0]] <= s_reg.held;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Contacts go back to USB as soon as it is enabled again
    assign MEAS_START_O = s_reg.start;
    assign MEAS_CFG_O = s_reg.cfg;
    assign OUT_DATA_O = s_reg.out;
    assign BUSY_O = !(s_reg.st == mtc_pkg::MTC_ST_IDLE);
    assign WAIT_TRIG_O = (s_reg.st == mtc_pkg::MTC_ST_WAIT);
    assign PF_ACTIVE_O = !USB_ENABLE_I; // R4
    assign USB_DM_O = s_reg.pass_n; // R3
    assign USB_DP_O = s_reg.fail_n; // R3
    assign USB_DM_OE_O = !USB_ENABLE_I; // R3 R4
    assign USB_DP_OE_O = !USB_ENABLE_I;
endmodule : mtc_ctrl

// ### testbench/mtc_chk.sv
`timescale 1ns/1ns
module mtc_chk #(
    parameter int PULSE_CYCLES = mtc_pkg::PULSE_CYC
) (
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    input wire logic CMD_VALID_I,
    input wire mtc_pkg::mtc_cmd_t CMD_I,
    input wire logic BUSY_O,
    input wire logic WAIT_TRIG_O,
    input wire logic MEAS_START_O,
    input wire mtc_pkg::mtc_rdg_t OUT_DATA_O,
    input wire logic OUT_READY_I,
    input wire logic USB_ENABLE_I,
    input wire logic USB_DM_O,
    input wire logic USB_DP_O,
    input wire logic USB_DM_OE_O,
    input wire logic USB_DP_OE_O,
    input wire logic PF_ACTIVE_O
);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);
    logic take;
    logic v_reg;
    logic vr_reg;
    logic load;
    logic [31:0] since_reg;
    // A fresh word stands in the output slot this cycle
    assign load = OUT_DATA_O.valid && (!v_reg || vr_reg);
    // Cycles since the last word was loaded, saturating
    always_ff @(posedge CLOCK_I) begin
        v_reg <= !SYS_RST_I && OUT_DATA_O.valid;
        vr_reg <= !SYS_RST_I && OUT_DATA_O.valid && OUT_READY_I;
        if (SYS_RST_I) begin
            since_reg <= 32'h0000_0000;
        end else if (load) begin
            since_reg <= 32'h0000_0001;
        end else if (since_reg != 32'hFFFF_FFFF) begin
            since_reg <= since_reg + 32'h0000_0001;
        end
    end
    // Commands count only when the machine is idle
    assign take = CMD_VALID_I && !BUSY_O;
    a_oe_follow: assert property (USB_DM_OE_O == !USB_ENABLE_I
        && USB_DP_OE_O == !USB_ENABLE_I) else $error("oe level wrong");
    a_pf_enable: assert property (PF_ACTIVE_O == !USB_ENABLE_I)
        else $error("pass fail enable wrong");
    a_read_wait: assert property (take && CMD_I == mtc_pkg::MTC_CMD_READ
        |=> WAIT_TRIG_O) else $error("read did not wait");
    a_init_wait: assert property (take && CMD_I == mtc_pkg::MTC_CMD_INIT
        |=> WAIT_TRIG_O) else $error("init did not wait");
    a_conf_idle: assert property (take && CMD_I == mtc_pkg::MTC_CMD_CONF
        |=> !BUSY_O [*2]) else $error("configure left idle");
    a_start_trig: assert property (MEAS_START_O |-> $past(WAIT_TRIG_O))
        else $error("start without wait state");
    a_pass_low: assert property ($rose(OUT_DATA_O.valid) && OUT_DATA_O.pass
        |-> !USB_DM_O) else $error("pass line not low");
    a_fail_low: assert property ($rose(OUT_DATA_O.valid) && !OUT_DATA_O.pass
        |-> !USB_DP_O) else $error("fail line not low");
    // A later word may cut a pulse short, so only a lapse is timed
    a_pulse_hold: assert property ($rose(USB_DM_O) && !load
        |-> since_reg == 32'(PULSE_CYCLES)) else $error("pass pulse length");
    a_fail_hold: assert property ($rose(USB_DP_O) && !load
        |-> since_reg == 32'(PULSE_CYCLES)) else $error("fail pulse length");
    a_out_hold: assert property (OUT_DATA_O.valid && !OUT_READY_I
        |=> $stable(OUT_DATA_O)) else $error("word moved while stalled");
endmodule : mtc_chk

// ### testbench/mtc_host.sv
`timescale 1ns/1ns
module mtc_host (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic stall_i,
    output mtc_pkg::mtc_rdg_t result_o,
    output logic ready_o
);
    logic [2:0] dly_reg;
    logic [23:0] seq_reg;
    always_ff @(posedge clk_i) begin
        dly_reg <= rst_i ? 3'h0 : {dly_reg[1:0], start_i};
        if (rst_i) seq_reg <= 24'h000001;
        else if (dly_reg[2]) seq_reg <= seq_reg + 24'h000001;
    end
    // Odd readings pass the limit test so both lines get exercised
    assign result_o = '{dly_reg[2], seq_reg, seq_reg[0]};
    assign ready_o = !stall_i;
endmodule : mtc_host

// ### testbench/test_meas_trigger_ctrl_passfail_out.sv
`timescale 1ns/1ns
module test_meas_trigger_ctrl_passfail_out;
    typedef struct {
        mtc_pkg::mtc_cmd_t cmd;
        mtc_pkg::mtc_src_t src;
        int cnt;
        int words;
    } mtc_row_t;
    logic CLOCK_I = 1'b0, SYS_RST_I = 1'b1, CMD_VALID_I = 1'b0;
    logic BUS_TRIG_I = 1'b0, EXT_TRIG_I = 1'b0, USB_ENABLE_I = 1'b0;
    logic stall = 1'b0, OUT_READY_I, MEAS_START_O, BUSY_O, WAIT_TRIG_O;
    logic USB_DM_O, USB_DP_O;
    logic [1:0] w;
    logic [15:0] MEAS_CFG_O, CMD_CFG_I = 16'h0000, CMD_COUNT_I = 16'h0000;
    mtc_pkg::mtc_cmd_t CMD_I = mtc_pkg::MTC_CMD_NONE;
    mtc_pkg::mtc_src_t TRIG_SRC_I = mtc_pkg::MTC_SRC_IMM;
    mtc_pkg::mtc_rdg_t MEAS_RESULT_I, OUT_DATA_O;
    int miscompares = 0, checked = 0, nv = 1, base = 1;
    mtc_row_t rows [6] = '{'{mtc_pkg::MTC_CMD_CONF, mtc_pkg::MTC_SRC_IMM, 0, 0},
        '{mtc_pkg::MTC_CMD_READ, mtc_pkg::MTC_SRC_IMM, 2, 2},
        '{mtc_pkg::MTC_CMD_MEAS, mtc_pkg::MTC_SRC_IMM, 0, 1},
        '{mtc_pkg::MTC_CMD_READ, mtc_pkg::MTC_SRC_BUS, 1, 1},
        '{mtc_pkg::MTC_CMD_INIT, mtc_pkg::MTC_SRC_EXT, 2, 0},
        '{mtc_pkg::MTC_CMD_FETCH, mtc_pkg::MTC_SRC_IMM, 0, 2}};
    mtc_ctrl #(.PULSE_CYCLES(20)) mtc_ctrl_i (.CLOCK_I, .SYS_RST_I,
        .CMD_VALID_I, .CMD_I, .CMD_CFG_I, .CMD_COUNT_I, .TRIG_SRC_I,
        .BUS_TRIG_I, .EXT_TRIG_I, .MEAS_START_O, .MEAS_CFG_O,
        .MEAS_RESULT_I, .OUT_DATA_O, .OUT_READY_I, .BUSY_O, .WAIT_TRIG_O,
        .USB_ENABLE_I, .USB_DM_O, .USB_DP_O, .USB_DM_OE_O(),
        .USB_DP_OE_O(), .PF_ACTIVE_O());
    mtc_host mtc_host_i (.clk_i(CLOCK_I), .rst_i(SYS_RST_I),
        .start_i(MEAS_START_O), .stall_i(stall), .result_o(MEAS_RESULT_I),
        .ready_o(OUT_READY_I));
    always #20 CLOCK_I = ~CLOCK_I;
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    task automatic check(input string name, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic issue(input mtc_pkg::mtc_cmd_t c, mtc_pkg::mtc_src_t s,
                         input int n);
        @(posedge CLOCK_I);
        CMD_I <= c;
        TRIG_SRC_I <= s;
        CMD_COUNT_I <= 16'(n);
        CMD_VALID_I <= 1'b1;
        @(posedge CLOCK_I);
        CMD_VALID_I <= 1'b0;
    endtask : issue
    // Count words taken by the host until the machine is idle and empty
    task automatic collect(input int n);
        int got;
        got = 0;
        for (int t = 0; t < 400; t++) begin
            @(negedge CLOCK_I);
            if (OUT_DATA_O.valid && OUT_READY_I) begin
                check("value", OUT_DATA_O.value, nv);
                check("pass", OUT_DATA_O.pass, nv[0]);
                nv++;
                got++;
            end
            if (BUSY_O === 1'b0 && OUT_DATA_O.valid === 1'b0) break;
        end
        check("words", got, n);
        check("idle", BUSY_O, 0);
    endtask : collect
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge CLOCK_I);
        SYS_RST_I <= 1'b0;
        for (int r = 0; r < 6; r++) begin
            w = rows[r].src == mtc_pkg::MTC_SRC_BUS ? 2'b01 :
                rows[r].src == mtc_pkg::MTC_SRC_EXT ? 2'b10 : 2'b00;
            @(posedge CLOCK_I);
            // Hold the unselected trigger high first to prove it is ignored
            {BUS_TRIG_I, EXT_TRIG_I} <= w;
            CMD_CFG_I <= 16'h5A00 + 16'(r);
            USB_ENABLE_I <= r[0];
            issue(rows[r].cmd, rows[r].src, rows[r].cnt);
            if (rows[r].cmd == mtc_pkg::MTC_CMD_INIT) base = nv;
            if (rows[r].cmd == mtc_pkg::MTC_CMD_INIT) nv += rows[r].cnt;
            if (rows[r].cmd == mtc_pkg::MTC_CMD_FETCH) nv = base;
            if (w != 2'b00) begin
                repeat (5) begin
                    @(negedge CLOCK_I);
                    check("early start", MEAS_START_O, 0);
                end
                @(posedge CLOCK_I);
                {EXT_TRIG_I, BUS_TRIG_I} <= w;
            end
            collect(rows[r].words);
            if (r < 3 && r != 1) check("cfg", MEAS_CFG_O, 16'h5A00 + r);
        end
        @(posedge CLOCK_I);
        {BUS_TRIG_I, EXT_TRIG_I} <= 2'b11;
        TRIG_SRC_I <= mtc_pkg::MTC_SRC_BUS;
        repeat (4) begin
            @(negedge CLOCK_I);
            check("idle trigger", MEAS_START_O | BUSY_O, 0);
        end
        issue(mtc_pkg::MTC_CMD_READ, mtc_pkg::MTC_SRC_IMM, 3);
        stall <= 1'b1;
        repeat (30) @(negedge CLOCK_I);
        check("held word", OUT_DATA_O.value, nv);
        check("stalled", BUSY_O, 1);
        @(posedge CLOCK_I);
        stall <= 1'b0;
        collect(3);
        issue(mtc_pkg::MTC_CMD_INIT, mtc_pkg::MTC_SRC_IMM, 3);
        repeat (2) @(posedge CLOCK_I);
        SYS_RST_I <= 1'b1;
        repeat (2) @(posedge CLOCK_I);
        SYS_RST_I <= 1'b0;
        @(negedge CLOCK_I);
        check("reset", {BUSY_O, USB_DM_O, USB_DP_O}, 3'h3);
        end_of_test();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge CLOCK_I);
        miscompares++;
        end_of_test();
    end
endmodule : test_meas_trigger_ctrl_passfail_out
bind mtc_ctrl mtc_chk #(.PULSE_CYCLES(PULSE_CYCLES)) mtc_chk_i (
    .CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I),
    .CMD_VALID_I(CMD_VALID_I), .CMD_I(CMD_I), .BUSY_O(BUSY_O),
    .WAIT_TRIG_O(WAIT_TRIG_O), .MEAS_START_O(MEAS_START_O),
    .OUT_DATA_O(OUT_DATA_O), .OUT_READY_I(OUT_READY_I),
    .USB_ENABLE_I(USB_ENABLE_I), .USB_DM_O(USB_DM_O), .USB_DP_O(USB_DP_O),
    .USB_DM_OE_O(USB_DM_OE_O), .USB_DP_OE_O(USB_DP_OE_O),
    .PF_ACTIVE_O(PF_ACTIVE_O));
